// ---- common/crf_params.svh ----
/*
 * Address map and value constants of the core register file.
 * Assumes inclusion by the package and by the register file module.
 */
`ifndef CRF_PARAMS_SVH
`define CRF_PARAMS_SVH

`define CRF_GRP_LOW     4'h0
`define CRF_GRP_CTRL    4'hf
`define CRF_PORT_MASK   16'h0074
`define CRF_LOW_GP_MASK 16'hff00
`define CRF_CTRL_MASK   16'hff8e
`define CRF_CTRL_GP_IDX 4'h0
`define CRF_RP_IDX      4'hd
`define CRF_BANK_STD    4'h0
`define CRF_BANK_D      4'hd
`define CRF_BANK_F      4'hf
`define CRF_ERFD_MASK   16'h0fff
`define CRF_ERFF_MASK   16'h01ff
`define CRF_RSVD_VAL    8'hff
`define CRF_PORT_A      4'h2
`define CRF_PORT_B      4'h4
`define CRF_PORT_C      4'h5
`define CRF_PORT_D      4'h6
`define CRF_PAIR_ONE    16'h0001

`endif

// ---- common/crf_pkg.sv ----
/*
 * Types of the core register file: operations, location kinds, states.
 * Assumes crf_params.svh sits on the include path.
 */
package crf_pkg;
    `include "crf_params.svh"

    typedef enum logic [5:0] {
        OP_RD8   = 6'h01,
        OP_WR8   = 6'h02,
        OP_RD16  = 6'h04,
        OP_WR16  = 6'h08,
        OP_INC16 = 6'h10,
        OP_DEC16 = 6'h20
    } crf_op_t;

    typedef enum logic [4:0] {
        K_GP   = 5'h01,
        K_PORT = 5'h02,
        K_CTRL = 5'h04,
        K_ERFD = 5'h08,
        K_ERFF = 5'h10
    } crf_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h1,
        ST_FETCH = 2'h2
    } crf_state_t;

    typedef logic [7:0] crf_byte_t;
endpackage

// ---- design/crf_gp_mem.sv ----
/*
 * One bank of general-purpose storage bytes, registered read data.
 * Assumes one write and one read per cycle, no same-address collision.
 */
`timescale 1ns/1ps
module crf_gp_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata_q
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clock)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= mem[raddr];
        end
    end
endmodule // crf_gp_mem

// ---- design/crf_register_file.sv ----
/*
 * Core register file: 256-byte standard space, ports, control registers,
 * expanded banks D and F group 0, byte/pair access and pair inc/dec.
 * Assumes the core holds req until accepted only while busy_q is low.
 */
// Operation
// - 256 byte locations, 8-bit address, readable and writable; here the seven reserved ones read ff and ignore writes
// - four port registers at locations 2, 4, 5 and 6
// - twelve control registers, 233 storage bytes, seven reserved locations
// - twenty-one more control registers live in expanded banks
// - pair access: even location is high byte, odd is low
// - every active register reached through the ordinary byte path
// - any storage byte supplies data or address operands
// - pair increment and decrement with carry between bytes
// - port access only by register reads and writes
// - control registers sit in the top group of sixteen
// - lowest group: ports below, storage in upper eight
// - only group 0 of expanded banks D and F exists
// - 4-bit working register number selects within current group
`timescale 1ns/1ps
`include "crf_params.svh"
module crf_register_file (
    input  wire logic            clock,
    input  wire logic            reset,
    input  wire logic            req,
    input  wire crf_pkg::crf_op_t op,
    input  wire logic            work_mode,
    input  wire logic [7:0]      addr,
    input  wire logic [15:0]     wdata,
    input  wire logic [3:0][7:0] port_pin,
    output logic      [15:0]     rd_data_q,
    output logic                 done_q,
    output logic                 busy_q,
    output logic      [3:0][7:0] port_out_q,
    output logic     [15:0][7:0] ctrl_q,
    output logic     [15:0][7:0] erf_d_q,
    output logic     [15:0][7:0] erf_f_q
);
    import crf_pkg::*;

    localparam logic [15:0] PORT_MASK   = `CRF_PORT_MASK;
    localparam logic [15:0] LOW_GP_MASK = `CRF_LOW_GP_MASK;
    localparam logic [15:0] CTRL_MASK   = `CRF_CTRL_MASK;
    localparam logic [15:0] ERFD_MASK   = `CRF_ERFD_MASK;
    localparam logic [15:0] ERFF_MASK   = `CRF_ERFF_MASK;

    crf_state_t      state_q;
    crf_op_t         lat_op_q;
    logic [7:0]      lat_addr_q;
    logic [3:0][7:0] pin_s1_q;
    logic [3:0][7:0] pin_s2_q;
    logic [3:0][7:0] pin_s3_q;
    logic [3:0][7:0] port_in_q;
    logic [7:0]      rp;
    logic [7:0]      eff;
    logic [7:0]      cur;
    logic [7:0]      pa;
    logic            take;
    logic            kind_ok_e;
    logic            kind_ok_o;
    crf_kind_t       kind_e;
    crf_kind_t       kind_o;
    logic            wr_e;
    logic            wr_o;
    crf_byte_t       wd_e;
    crf_byte_t       wd_o;
    crf_byte_t       mem_e;
    crf_byte_t       mem_o;
    crf_byte_t       by_e;
    crf_byte_t       by_o;
    logic [15:0]     pair_val;
    logic [15:0]     new_val;

    // decode of one location; valid low means reserved or absent
    function automatic logic loc_kind(input logic [7:0] a, input logic [3:0] bank, output crf_kind_t k);
        logic [3:0] g;
        logic [3:0] i;
        g = a[7:4];
        i = a[3:0];
        k = K_GP;
        if (bank != `CRF_BANK_STD && g == `CRF_GRP_LOW)
        begin
            k = (bank == `CRF_BANK_D) ? K_ERFD : K_ERFF;
            return (bank == `CRF_BANK_D && ERFD_MASK[i]) || (bank == `CRF_BANK_F && ERFF_MASK[i]);
        end
        if (g == `CRF_GRP_LOW)
        begin
            k = PORT_MASK[i] ? K_PORT : K_GP;
            return PORT_MASK[i] || LOW_GP_MASK[i];
        end
        if (g == `CRF_GRP_CTRL)
        begin
            k = CTRL_MASK[i] ? K_CTRL : K_GP;
            return CTRL_MASK[i] || i == `CRF_CTRL_GP_IDX;
        end
        return 1'b1;
    endfunction

    function automatic logic [1:0] port_idx(input logic [3:0] i);
        unique case (i)
            `CRF_PORT_A: return 2'h0;
            `CRF_PORT_B: return 2'h1;
            `CRF_PORT_C: return 2'h2;
            default:     return 2'h3;
        endcase
    endfunction

    function automatic crf_byte_t rd_byte(input logic ok, input crf_kind_t k, input logic [3:0] i,
                                          input crf_byte_t m);
        if (!ok)
        begin
            return `CRF_RSVD_VAL;
        end
        unique case (k)
            K_PORT:  return port_in_q[port_idx(i)];
            K_CTRL:  return ctrl_q[i];
            K_ERFD:  return erf_d_q[i];
            K_ERFF:  return erf_f_q[i];
            default: return m;
        endcase
    endfunction

    assign rp       = ctrl_q[`CRF_RP_IDX];
    assign eff      = work_mode ? {rp[7:4], addr[3:0]} : addr;
    assign take     = req && state_q == ST_IDLE;
    assign cur      = (state_q == ST_FETCH) ? lat_addr_q : eff;
    assign pa       = {cur[7:1], 1'b0};
    // decode kept procedural: the decode function hands the kind back through an output argument
    always_comb
    begin
        kind_e    = K_GP;
        kind_o    = K_GP;
        kind_ok_e = loc_kind(pa, rp[3:0], kind_e);
        kind_ok_o = loc_kind({cur[7:1], 1'b1}, rp[3:0], kind_o);
    end
    assign by_e     = rd_byte(kind_ok_e, kind_e, pa[3:0], mem_e);
    assign by_o     = rd_byte(kind_ok_o, kind_o, {pa[3:1], 1'b1}, mem_o);
    assign pair_val = {by_e, by_o};
    assign new_val  = (lat_op_q == OP_DEC16) ? pair_val - `CRF_PAIR_ONE
                                             : pair_val + `CRF_PAIR_ONE;

    always_comb
    begin
        wr_e = 1'b0;
        wr_o = 1'b0;
        wd_e = wdata[7:0];
        wd_o = wdata[7:0];
        if (take && op == OP_WR8)
        begin
            wr_e = ~eff[0];
            wr_o = eff[0];
        end
        else if (take && op == OP_WR16)
        begin
            wr_e = 1'b1;
            wr_o = 1'b1;
            wd_e = wdata[15:8];
        end
        else if (state_q == ST_FETCH && (lat_op_q == OP_INC16 || lat_op_q == OP_DEC16))
        begin
            wr_e = 1'b1;
            wr_o = 1'b1;
            wd_e = new_val[15:8];
            wd_o = new_val[7:0];
        end
    end

    crf_gp_mem #(.WIDTH(8), .DEPTH(128), .AW(7)) u_even (
        .clock   (clock),
        .reset   (reset),
        .we      (wr_e && kind_ok_e && kind_e == K_GP),
        .waddr   (pa[7:1]),
        .wdata   (wd_e),
        .raddr   (eff[7:1]),
        .rdata_q (mem_e)
    );

    crf_gp_mem #(.WIDTH(8), .DEPTH(128), .AW(7)) u_odd (
        .clock   (clock),
        .reset   (reset),
        .we      (wr_o && kind_ok_o && kind_o == K_GP),
        .waddr   (pa[7:1]),
        .wdata   (wd_o),
        .raddr   (eff[7:1]),
        .rdata_q (mem_o)
    );

    // sequencing: reads and pair updates spend one fetch cycle
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_q    <= ST_IDLE;
            lat_op_q   <= OP_RD8;
            lat_addr_q <= '0;
            busy_q     <= 1'b0;
            done_q     <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            unique case (state_q)
                ST_IDLE:
                begin
                    if (take)
                    begin
                        lat_op_q   <= op;
                        lat_addr_q <= eff;
                        if (op == OP_WR8 || op == OP_WR16)
                        begin
                            done_q <= 1'b1;
                        end
                        else
                        begin
                            state_q <= ST_FETCH;
                            busy_q  <= 1'b1;
                        end
                    end
                end
                ST_FETCH:
                begin
                    state_q <= ST_IDLE;
                    busy_q  <= 1'b0;
                    done_q  <= 1'b1;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            rd_data_q <= '0;
        end
        else if (state_q == ST_FETCH)
        begin
            if (lat_op_q == OP_RD8)
            begin
                rd_data_q <= {8'h00, lat_addr_q[0] ? by_o : by_e};
            end
            else if (lat_op_q == OP_RD16)
            begin
                rd_data_q <= pair_val;
            end
            else
            begin
                rd_data_q <= new_val;
            end
        end
    end

    // pin inputs: three flops, accepted where the last two agree
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pin_s1_q  <= '0;
            pin_s2_q  <= '0;
            pin_s3_q  <= '0;
            port_in_q <= '0;
        end
        else
        begin
            pin_s1_q  <= port_pin;
            pin_s2_q  <= pin_s1_q;
            pin_s3_q  <= pin_s2_q;
            port_in_q <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (port_in_q & (pin_s2_q ^ pin_s3_q));
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            port_out_q <= '0;
        end
        else
        begin
            if (wr_e && kind_ok_e && kind_e == K_PORT)
            begin
                port_out_q[port_idx(pa[3:0])] <= wd_e;
            end
            if (wr_o && kind_ok_o && kind_o == K_PORT)
            begin
                port_out_q[port_idx({pa[3:1], 1'b1})] <= wd_o;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ctrl_q  <= '0;
            erf_d_q <= '0;
            erf_f_q <= '0;
        end
        else
        begin
            if (wr_e && kind_ok_e)
            begin
                if (kind_e == K_CTRL) ctrl_q[pa[3:0]] <= wd_e;
                if (kind_e == K_ERFD) erf_d_q[pa[3:0]] <= wd_e;
                if (kind_e == K_ERFF) erf_f_q[pa[3:0]] <= wd_e;
            end
            if (wr_o && kind_ok_o)
            begin
                if (kind_o == K_CTRL) ctrl_q[{pa[3:1], 1'b1}] <= wd_o;
                if (kind_o == K_ERFD) erf_d_q[{pa[3:1], 1'b1}] <= wd_o;
                if (kind_o == K_ERFF) erf_f_q[{pa[3:1], 1'b1}] <= wd_o;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    read_latency_a: assert property ((take && (op == OP_RD8 || op == OP_RD16)) |-> ##2 done_q)
        else $error("read not answered two cycles after request");
    write_done_a: assert property ((take && op == OP_WR16) |=> done_q && !busy_q)
        else $error("pair write not done in one cycle");
    pair_inc_a: assert property ((state_q == ST_FETCH && lat_op_q == OP_INC16)
                                 |=> rd_data_q == $past(pair_val) + 16'h0001)
        else $error("pair increment wrong");
    pair_dec_a: assert property ((state_q == ST_FETCH && lat_op_q == OP_DEC16)
                                 |=> rd_data_q == $past(pair_val) - 16'h0001)
        else $error("pair decrement wrong");
    rsvd_read_a: assert property ((state_q == ST_FETCH && lat_op_q == OP_RD16 && !kind_ok_e)
                                  |=> rd_data_q[15:8] == 8'hff)
        else $error("reserved location read wrong value");
    port_pair_a: assert property ((take && op == OP_WR16 && eff == 8'h04 && rp[3:0] == 4'h0)
        |=> port_out_q[1] == $past(wdata[15:8]) && port_out_q[2] == $past(wdata[7:0]))
        else $error("port pair not written high then low");
    port_byte_a: assert property ((take && op == OP_WR8 && eff == 8'h02 && rp[3:0] == 4'h0)
                                  |=> port_out_q[0] == $past(wdata[7:0]))
        else $error("port byte write lost");
    ctrl_write_a: assert property ((take && op == OP_WR8 && eff == 8'hf1 && rp[3:0] == 4'h0)
                                   |=> ctrl_q[1] == $past(wdata[7:0]))
        else $error("control register write lost");
    erf_write_a: assert property ((take && op == OP_WR8 && eff == 8'h00 && rp[3:0] == 4'hd)
                                  |=> erf_d_q[0] == $past(wdata[7:0]))
        else $error("expanded bank write lost");
    work_reg_a: assert property ((take && work_mode) |=> lat_addr_q[7:4] == $past(rp[7:4]))
        else $error("working register group not taken from pointer");

    rd16_c: cover property (take && op == OP_RD16 ##2 done_q);
    inc_carry_c: cover property (state_q == ST_FETCH && lat_op_q == OP_INC16 && pair_val[7:0] == 8'hff);
    erf_f_c: cover property (wr_e && kind_ok_e && kind_e == K_ERFF);
endmodule // crf_register_file

// ---- testbench/crf_core_model.sv ----
/*
 * Core-side request model: issues one register file request at a time.
 * Assumes done_q answers within eight cycles of the taking edge.
 */
`timescale 1ns/1ps
module crf_core_model (
    input  wire logic         clock,
    input  wire logic         busy_q,
    input  wire logic         done_q,
    input  wire logic [15:0]  rd_data_q,
    output logic              req,
    output crf_pkg::crf_op_t  op,
    output logic              work_mode,
    output logic      [7:0]   addr,
    output logic      [15:0]  wdata
);
    import crf_pkg::*;

    initial
    begin
        req = 1'b0;
        op = OP_RD8;
        work_mode = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
    end

    task automatic xfer(input crf_op_t o, input logic m, input logic [7:0] a,
                        input logic [15:0] d, output logic [15:0] q, output logic ok);
        int n;
        ok = 1'b0;
        q = 16'hxxxx;
        @(negedge clock);
        while (busy_q !== 1'b0)
            @(negedge clock);
        req = 1'b1;
        op = o;
        work_mode = m;
        addr = a;
        wdata = d;
        @(negedge clock);
        // taken at the edge just passed; drop so it is not taken twice
        req = 1'b0;
        addr = ~a;
        wdata = ~d;
        for (n = 0; n < 8 && ok !== 1'b1; n++)
        begin
            if (done_q === 1'b1)
            begin
                q = rd_data_q;
                ok = 1'b1;
            end
            else
                @(negedge clock);
        end
    endtask
endmodule // crf_core_model

// ---- testbench/test_cpu_register_file.sv ----
/*
 * Self-checking bench of the core register file, one task per scenario.
 * Assumes crf_core_model drives the request side.
 */
`timescale 1ns/1ps
module test_cpu_register_file;
    import crf_pkg::*;

    logic            clock = 1'b0;
    logic            reset;
    logic [3:0][7:0] port_pin;
    logic [15:0]     rd_data_q;
    logic            done_q;
    logic            busy_q;
    logic [3:0][7:0] port_out_q;
    logic [15:0][7:0] ctrl_q;
    logic [15:0][7:0] erf_d_q;
    logic [15:0][7:0] erf_f_q;
    logic            req;
    crf_op_t         op;
    logic            work_mode;
    logic [7:0]      addr;
    logic [15:0]     wdata;
    logic [15:0]     rq;
    logic            ok;
    logic            wm = 1'b0;
    int              bad_count = 0;
    int              n_compared = 0;
    int              n_busy = 0;

    always #12.5 clock = ~clock;

    // busy cycles seen, one per read-type request
    always @(negedge clock)
        if (busy_q === 1'b1)
            n_busy++;

    crf_register_file dut (.clock(clock), .reset(reset), .req(req), .op(op), .work_mode(work_mode),
        .addr(addr), .wdata(wdata), .port_pin(port_pin), .rd_data_q(rd_data_q), .done_q(done_q),
        .busy_q(busy_q), .port_out_q(port_out_q), .ctrl_q(ctrl_q), .erf_d_q(erf_d_q), .erf_f_q(erf_f_q));

    crf_core_model core (.clock(clock), .busy_q(busy_q), .done_q(done_q), .rd_data_q(rd_data_q),
        .req(req), .op(op), .work_mode(work_mode), .addr(addr), .wdata(wdata));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic go(input crf_op_t o, input logic [7:0] a, input logic [15:0] d);
        int b0;
        b0 = n_busy;
        core.xfer(o, wm, a, d, rq, ok);
        check("done", {15'h0000, ok}, 16'h0001);
        check("busy", 16'(n_busy - b0), (o == OP_WR8 || o == OP_WR16) ? 16'h0000 : 16'h0001);
    endtask

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic t_reset;
        logic lit;
        lit = |{rd_data_q, done_q, busy_q, port_out_q, ctrl_q, erf_d_q, erf_f_q};
        check("reset outs", {15'h0000, lit}, 16'h0000);
    endtask

    task automatic t_storage;
        int i;
        for (i = 8; i <= 240; i++)
            go(OP_WR8, 8'(i), {8'h00, 8'(i) ^ 8'h5a});
        for (i = 8; i <= 240; i++)
        begin
            go(OP_RD8, 8'(i), 16'h0000);
            check("storage", rq, {8'h00, 8'(i) ^ 8'h5a});
        end
    endtask

    task automatic t_reserved;
        logic [7:0] rsv [7] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'hf4, 8'hf5, 8'hf6};
        int i;
        for (i = 0; i < 7; i++)
        begin
            go(OP_WR8, rsv[i], 16'h0000);
            go(OP_RD8, rsv[i], 16'h0000);
            check("reserved", rq, 16'h00ff);
        end
        check("ctrl f4..f6", {8'h00, ctrl_q[4] | ctrl_q[5] | ctrl_q[6]}, 16'h0000);
        go(OP_RD8, 8'hf0, 16'h0000);
        check("f0 kept", rq, 16'h00aa);
        go(OP_RD16, 8'h01, 16'h0000);
        check("reserved pair", rq, 16'hffff);
    endtask

    task automatic t_ports;
        logic [7:0] loc [4] = '{8'h02, 8'h04, 8'h05, 8'h06};
        logic [3:0][7:0] pins;
        int i;
        pins = {8'h3c, 8'hc3, 8'h69, 8'h96};
        @(negedge clock);
        port_pin = pins;
        repeat (6) @(negedge clock);
        for (i = 0; i < 4; i++)
        begin
            go(OP_RD8, loc[i], 16'h0000);
            check("port read", rq, {8'h00, pins[i]});
            go(OP_WR8, loc[i], {8'h00, ~pins[i]});
            check("port latch", {8'h00, port_out_q[i]}, {8'h00, ~pins[i]});
        end
        go(OP_WR16, 8'h04, 16'ha55a);
        check("port pair", {port_out_q[1], port_out_q[2]}, 16'ha55a);
    endtask

    task automatic t_pair;
        go(OP_WR16, 8'h20, 16'h12ff);
        go(OP_RD8, 8'h20, 16'h0000);
        check("pair even", rq, 16'h0012);
        go(OP_RD8, 8'h21, 16'h0000);
        check("pair odd", rq, 16'h00ff);
        go(OP_INC16, 8'h21, 16'h0000);
        check("inc carry", rq, 16'h1300);
        go(OP_RD16, 8'h20, 16'h0000);
        check("inc stored", rq, 16'h1300);
        go(OP_WR16, 8'h40, 16'h0000);
        go(OP_DEC16, 8'h40, 16'h0000);
        check("dec wrap", rq, 16'hffff);
        go(OP_DEC16, 8'h41, 16'h0000);
        go(OP_RD8, 8'h41, 16'h0000);
        check("dec low", rq, 16'h00fe);
        go(OP_WR16, 8'h50, 16'habcd);
        go(OP_RD16, 8'h51, 16'h0000);
        check("pair whole", rq, 16'habcd);
    endtask

    task automatic t_ctrl;
        logic [7:0] v;
        int i;
        for (i = 1; i < 16; i++)
        begin
            if (i == 4 || i == 5 || i == 6 || i == 13)
                continue;
            v = 8'(i * 17) ^ 8'h0f;
            go(OP_WR8, {4'hf, 4'(i)}, {8'h00, v});
            check("ctrl latch", {8'h00, ctrl_q[i]}, {8'h00, v});
            go(OP_RD8, {4'hf, 4'(i)}, 16'h0000);
            check("ctrl read", rq, {8'h00, v});
        end
        check("f0 not ctrl", {8'h00, ctrl_q[0]}, 16'h0000);
    endtask

    task automatic t_bank;
        int b;
        int i;
        int live;
        for (b = 0; b < 2; b++)
        begin
            live = (b == 0) ? 12 : 9;
            go(OP_WR8, 8'hfd, (b == 0) ? 16'h000d : 16'h000f);
            for (i = 0; i < 16; i++)
                go(OP_WR8, 8'(i), 16'h0040 + 16'(i));
            for (i = 0; i < 16; i++)
            begin
                go(OP_RD8, 8'(i), 16'h0000);
                check("bank read", rq, (i < live) ? 16'h0040 + 16'(i) : 16'h00ff);
                if (i < live)
                    check("bank q", {8'h00, (b == 0) ? erf_d_q[i] : erf_f_q[i]}, 16'h0040 + 16'(i));
            end
        end
        go(OP_WR8, 8'hfd, 16'h0000);
        go(OP_RD8, 8'h08, 16'h0000);
        check("bank 0 back", rq, 16'h0052);
    endtask

    task automatic t_work;
        go(OP_WR8, 8'hfd, 16'h0030);
        check("pointer", {8'h00, ctrl_q[13]}, 16'h0030);
        wm = 1'b1;
        go(OP_WR8, 8'h05, 16'h0077);
        go(OP_RD8, 8'h0a, 16'h0000);
        check("work read", rq, 16'h0060);
        wm = 1'b0;
        go(OP_RD8, 8'h35, 16'h0000);
        check("work write", rq, 16'h0077);
        go(OP_WR8, 8'hfd, 16'h0000);
    endtask

    initial
    begin
        reset = 1'b1;
        port_pin = '0;
        repeat (8) @(negedge clock);
        t_reset;
        reset = 1'b0;
        t_storage;
        t_reserved;
        t_ports;
        t_pair;
        t_ctrl;
        t_bank;
        t_work;
        conclude;
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        bad_count++;
        conclude;
    end
endmodule // test_cpu_register_file
